// ===== include/iso_pkg.sv
// Package for the serial I/Q output framer: register map, field positions, carrier types
package iso_pkg;

   // Register offsets on the configuration port
   localparam logic [5:0] ISO_ADDR_CTRL_A = 6'h18;
   localparam logic [5:0] ISO_ADDR_CTRL_B = 6'h19;
   localparam logic [5:0] ISO_ADDR_RATE = 6'h1A;

   // Reset values
   localparam logic [7:0] ISO_CTRL_A_RST = 8'h12;
   localparam logic [7:0] ISO_CTRL_B_RST = 8'h07;
   localparam logic [3:0] ISO_RATE_RST = 4'h1;

   // Control A field positions
   localparam int ISO_A_ALT_GAIN = 7;
   localparam int ISO_A_EMBED_GAIN = 6;
   localparam int ISO_A_EMBED_FRAMING = 5;
   localparam int ISO_A_FP_HIZ = 4;
   localparam int ISO_A_FP_INVERT = 3;
   localparam int ISO_A_FP_LATE = 2;
   localparam int ISO_A_BCLK_HIZ = 1;
   localparam int ISO_A_BCLK_INVERT = 0;

   // Control B field positions
   localparam int ISO_B_FOUR_WIRE = 7;
   localparam int ISO_B_WIDTH = 3;
   localparam int ISO_B_DRIVE_HI = 2;
   localparam int ISO_B_DRIVE_LO = 0;

   // Frame geometry and reset-count limit
   localparam int ISO_FRAME_W = 96;
   localparam int ISO_MAX_BYTES = 8;
   localparam logic [6:0] ISO_BYTE_BITS = 7'h08;
   localparam logic [6:0] ISO_FRAMED_BITS = 7'h0A;
   localparam logic [6:0] ISO_TAIL_BITS = 7'h0A;
   localparam logic [3:0] ISO_BYTES_NARROW = 4'h2;
   localparam logic [3:0] ISO_BYTES_WIDE = 4'h3;
   localparam logic [1:0] ISO_RST_CNT_MAX = 2'h3;

   typedef enum logic [1:0] {
      ISO_IDLE = 2'b01,
      ISO_SEND = 2'b10
   } iso_state_t;

   // One decimated output sample with its side information
   typedef struct packed {
      logic valid;
      logic [23:0] i_word;
      logic [23:0] q_word;
      logic [7:0] atten;
      logic [5:0] signal_strength_field;
   } iso_sample_t;

   // Configuration port access
   typedef struct packed {
      logic wr;
      logic [5:0] addr;
      logic [7:0] wdata;
   } iso_cfg_t;

   // Pins toward the host
   typedef struct packed {
      logic frame_pulse;
      logic frame_pulse_oe_n;
      logic serial_bit_clock_out;
      logic bit_clock_oe_n;
      logic serial_data_out_a;
   } iso_pins_t;

   // Complete state of the framer
   typedef struct packed {
      logic [7:0] serial_out_ctrl_a;
      logic [7:0] serial_out_ctrl_b;
      logic [3:0] serial_out_rate;
      logic [7:0] rdata;
      iso_state_t st;
      logic [3:0] div_cnt;
      logic bclk;
      logic pend;
      iso_sample_t held;
      logic [ISO_FRAME_W-1:0] shreg;
      logic [6:0] left;
      logic [6:0] sent;
      logic [1:0] rst_cnt;
      logic alt_sel;
      logic fp;
      logic dout;
   } iso_regs_t;

endpackage : iso_pkg

// ===== hdl/iso_framer.sv
// Serial I/Q output framer: packs decimated samples into frames for the host serial port
// Overview of operation
// - Three-wire mode drives frame pulse, bit clock and serial data to the host.
// - Two-wire mode embeds framing in data; only bit clock and data carry meaning.
// - One frame per decimated sample, so frame rate is modulator clock over decimation.
// - Frame sends I word then Q word, 16 or 24 bits, two's complement, MSB first.
// - Embed-gain bit appends attenuation byte then reset-count/strength byte after Q.
// - Attenuation byte carries the 8-bit attenuation setting, 0 none to 255 full.
// - Status byte holds 2-bit reset count above 6-bit signal strength.
// - Reset count reports events since last report and saturates at three.
// - Signal strength is a linear first-stage estimate, 60 meaning full scale.
// - Alternate bit clear: both extra bytes sent as one 16-bit word every frame.
// - Alternate bit set: bytes alternate per frame; attenuation LSB 0, status LSB 1.
// - Embedded framing wraps bytes with low start, high stop, ends with ten highs.
// - Embedded framing keeps frame pulse low or high impedance per its hiz bit.
// - Frame pulse may be inverted and delayed one bit; delay ignored with embedding.
// - Bit clock may be inverted or placed in high impedance.
// - Bit clock is modulator clock divided by the 4-bit rate, default one.
// - Remainder of each frame after the defined bits is filled with idle highs.
// - Default: one-bit frame pulse, then data shifted on rising bit clock edges.
module iso_framer (
   input wire logic mclk, // Modulator clock, 125 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input iso_pkg::iso_cfg_t cfg, // Register write port
   output iso_pkg::iso_pins_t pins, // Pins toward the host
   output logic [7:0] cfg_rdata, // Register read data for cfg.addr
   input iso_pkg::iso_sample_t sample, // Decimated sample, valid one cycle per output
   input wire logic mod_reset_event, // One-cycle pulse per modulator reset
   input wire logic gain_variant_flag, // Forces 16-bit words when high
   output logic [2:0] drive_level, // Output drive setting for the pad ring
   output logic four_wire_cfg // Four-wire configuration port select
);
   import iso_pkg::*;

   iso_regs_t s_q;
   iso_regs_t s_d;

   // Assembled frame and its length in bits
   logic [ISO_FRAME_W-1:0] frame_vec;
   logic [6:0] frame_len;
   logic bit_tick;
   logic last_phase;
   logic [3:0] rate_eff;
   logic embed;
   logic alt;
   logic embedded_framing;
   logic wide;
   logic starting;
   logic status_sent;
   logic [6:0] fp_slot;
   logic [7:0] status_byte;

   // Next register value for one address on a write, else current
   function automatic logic [7:0] wr_val(input iso_cfg_t c, input logic [5:0] a, input logic [7:0] cur);
      wr_val = (c.wr && c.addr == a) ? c.wdata : cur;
   endfunction : wr_val

   // Saturating add of one event
   function automatic logic [1:0] sat_inc(input logic [1:0] v, input logic ev);
      if (ev && v != ISO_RST_CNT_MAX) begin
         sat_inc = v + 2'h1;
      end else begin
         sat_inc = v;
      end
   endfunction : sat_inc

   always_comb begin
      rate_eff = (s_q.serial_out_rate == 4'h0) ? 4'h1 : s_q.serial_out_rate;
      last_phase = (s_q.div_cnt == rate_eff - 4'h1);
      // Tick on the edge that raises the bit clock, so data moves with its rising edge
      bit_tick = last_phase;
      embed = s_q.serial_out_ctrl_a[ISO_A_EMBED_GAIN];
      alt = s_q.serial_out_ctrl_a[ISO_A_ALT_GAIN];
      embedded_framing = s_q.serial_out_ctrl_a[ISO_A_EMBED_FRAMING];
      wide = s_q.serial_out_ctrl_b[ISO_B_WIDTH] && !gain_variant_flag;
      starting = bit_tick && s_q.st == ISO_IDLE && s_q.pend;
      status_sent = embed && (!alt || s_q.alt_sel);
      // Late pulse lands on the first data bit; embedded framing ignores it
      fp_slot = (s_q.serial_out_ctrl_a[ISO_A_FP_LATE] && !embedded_framing) ? 7'h01 : 7'h00;
      status_byte = {s_q.rst_cnt, s_q.held.signal_strength_field};
   end

   // Frame builder: byte list, then optional start/stop wrapping, left justified
   always_comb begin
      logic [7:0] bytes [ISO_MAX_BYTES];
      logic [3:0] nb;
      logic [ISO_FRAME_W-1:0] acc;
      logic [6:0] len;
      for (int k = 0; k < ISO_MAX_BYTES; k++) begin
         bytes[k] = 8'h00;
      end
      nb = 4'h0;
      acc = '0;
      len = 7'h00;
      if (wide) begin
         bytes[0] = s_q.held.i_word[23:16];
         bytes[1] = s_q.held.i_word[15:8];
         bytes[2] = s_q.held.i_word[7:0];
         bytes[3] = s_q.held.q_word[23:16];
         bytes[4] = s_q.held.q_word[15:8];
         bytes[5] = s_q.held.q_word[7:0];
         nb = ISO_BYTES_WIDE + ISO_BYTES_WIDE;
      end else begin
         bytes[0] = s_q.held.i_word[23:16];
         bytes[1] = s_q.held.i_word[15:8];
         bytes[2] = s_q.held.q_word[23:16];
         bytes[3] = s_q.held.q_word[15:8];
         nb = ISO_BYTES_NARROW + ISO_BYTES_NARROW;
      end
      if (embed && !alt) begin
         bytes[nb[2:0]] = s_q.held.atten;
         bytes[nb[2:0] + 3'h1] = status_byte;
         nb = nb + 4'h2;
      end else if (embed) begin
         if (s_q.alt_sel) begin
            bytes[nb[2:0]] = {status_byte[7:1], 1'b1};
         end else begin
            bytes[nb[2:0]] = {s_q.held.atten[7:1], 1'b0};
         end
         nb = nb + 4'h1;
      end
      // Non-embedded frames lead with one slot that carries the early pulse
      if (!embedded_framing) begin
         acc = {{(ISO_FRAME_W-1){1'b0}}, 1'b1};
         len = 7'h01;
      end
      for (int k = 0; k < ISO_MAX_BYTES; k++) begin
         if (4'(k) < nb) begin
            if (embedded_framing) begin
               acc = (acc << ISO_FRAMED_BITS) | {{(ISO_FRAME_W-10){1'b0}}, 1'b0, bytes[k], 1'b1};
               len = len + ISO_FRAMED_BITS;
            end else begin
               acc = (acc << ISO_BYTE_BITS) | {{(ISO_FRAME_W-8){1'b0}}, bytes[k]};
               len = len + ISO_BYTE_BITS;
            end
         end
      end
      if (embedded_framing) begin
         acc = (acc << ISO_TAIL_BITS) | {{(ISO_FRAME_W-10){1'b0}}, 10'h3FF};
         len = len + ISO_TAIL_BITS;
      end
      frame_vec = acc << (7'(ISO_FRAME_W) - len);
      frame_len = len;
   end

   // Next state
   always_comb begin
      s_d = s_q;
      s_d.serial_out_ctrl_a = wr_val(cfg, ISO_ADDR_CTRL_A, s_q.serial_out_ctrl_a);
      s_d.serial_out_ctrl_b = wr_val(cfg, ISO_ADDR_CTRL_B, s_q.serial_out_ctrl_b);
      s_d.serial_out_rate = 4'(wr_val(cfg, ISO_ADDR_RATE, {4'h0, s_q.serial_out_rate}));
      case (cfg.addr)
         ISO_ADDR_CTRL_A: s_d.rdata = s_q.serial_out_ctrl_a;
         ISO_ADDR_CTRL_B: s_d.rdata = s_q.serial_out_ctrl_b;
         ISO_ADDR_RATE: s_d.rdata = {4'h0, s_q.serial_out_rate};
         default: s_d.rdata = 8'h00;
      endcase

      // Bit clock divider: high in the first half of each bit period
      s_d.div_cnt = last_phase ? 4'h0 : s_q.div_cnt + 4'h1;
      // Five bits so that a divisor of fifteen does not wrap the half-period count
      s_d.bclk = ({1'b0, s_d.div_cnt} < (({1'b0, rate_eff} + 5'h01) >> 1));

      // Reset events accumulate until the status byte goes out
      if (starting && status_sent) begin
         s_d.rst_cnt = mod_reset_event ? 2'h1 : 2'h0;
      end else begin
         s_d.rst_cnt = sat_inc(s_q.rst_cnt, mod_reset_event);
      end

      // A new sample is held until its frame starts; a fresh one wins over the start
      if (starting) begin
         s_d.pend = 1'b0;
      end
      if (sample.valid) begin
         s_d.pend = 1'b1;
         s_d.held = sample;
         s_d.held.atten = sample.atten;
      end

      case (s_q.st)
         ISO_IDLE: begin
            if (bit_tick) begin
               s_d.dout = 1'b1;
               s_d.fp = 1'b0;
            end
            if (starting) begin
               s_d.shreg = frame_vec << 1;
               s_d.dout = frame_vec[ISO_FRAME_W-1];
               s_d.left = frame_len - 7'h1;
               s_d.sent = 7'h01;
               s_d.fp = !embedded_framing && fp_slot == 7'h00;
               s_d.alt_sel = (embed && alt) ? !s_q.alt_sel : s_q.alt_sel;
               s_d.st = (frame_len == 7'h1) ? ISO_IDLE : ISO_SEND;
            end
         end
         ISO_SEND: begin
            if (bit_tick) begin
               s_d.dout = s_q.shreg[ISO_FRAME_W-1];
               s_d.shreg = {s_q.shreg[ISO_FRAME_W-2:0], 1'b1};
               s_d.left = s_q.left - 7'h1;
               s_d.sent = s_q.sent + 7'h1;
               s_d.fp = !embedded_framing && s_q.sent == fp_slot;
               if (s_q.left == 7'h1) begin
                  s_d.st = ISO_IDLE;
               end
            end
         end
         default: begin
            s_d.st = ISO_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.serial_out_ctrl_a <= ISO_CTRL_A_RST;
         s_q.serial_out_ctrl_b <= ISO_CTRL_B_RST;
         s_q.serial_out_rate <= ISO_RATE_RST;
         s_q.st <= ISO_IDLE;
         s_q.dout <= 1'b1;
         s_q.shreg <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   // Divide by one passes the modulator clock itself; a divided flop cannot run that fast
   always_comb begin
      pins.serial_bit_clock_out = ((rate_eff == 4'h1) ? mclk : s_q.bclk)
         ^ s_q.serial_out_ctrl_a[ISO_A_BCLK_INVERT];
      pins.bit_clock_oe_n = s_q.serial_out_ctrl_a[ISO_A_BCLK_HIZ];
      pins.serial_data_out_a = s_q.dout;
      if (embedded_framing) begin
         pins.frame_pulse = 1'b0;
      end else begin
         pins.frame_pulse = s_q.fp ^ s_q.serial_out_ctrl_a[ISO_A_FP_INVERT];
      end
      pins.frame_pulse_oe_n = s_q.serial_out_ctrl_a[ISO_A_FP_HIZ];
   end

   assign cfg_rdata = s_q.rdata;
   assign drive_level = s_q.serial_out_ctrl_b[ISO_B_DRIVE_HI:ISO_B_DRIVE_LO];
   assign four_wire_cfg = s_q.serial_out_ctrl_b[ISO_B_FOUR_WIRE];

endmodule : iso_framer

// ===== bench/iso_framer_chk_sva.sv
// Checker for the serial I/Q output framer
module iso_framer_chk (
   input wire logic mclk, // Clock
   input wire logic rstn, // Reset
   input iso_pkg::iso_cfg_t cfg, // Register port
   input iso_pkg::iso_pins_t pins, // Host pins
   input wire logic [7:0] cfg_rdata, // Read data
   input iso_pkg::iso_sample_t sample // Sample in
);
   import iso_pkg::*;
   logic [7:0] a_q;
   logic [3:0] r_q;
   logic [3:0] qt_q;
   logic fa;
   logic ok;
   // Shadow copies of control A and rate, since only ports are visible
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         a_q <= ISO_CTRL_A_RST;
         r_q <= ISO_RATE_RST;
         qt_q <= 4'h0;
      end else begin
         if (cfg.wr && cfg.addr == ISO_ADDR_CTRL_A) a_q <= cfg.wdata;
         if (cfg.wr && cfg.addr == ISO_ADDR_RATE) r_q <= cfg.wdata[3:0];
         qt_q <= cfg.wr ? 4'h0 : qt_q + {3'h0, qt_q != 4'hF};
      end
   end
   assign fa = pins.frame_pulse ^ a_q[ISO_A_FP_INVERT];
   // Settings must have settled before timing is judged
   assign ok = qt_q == 4'hF && !a_q[ISO_A_EMBED_FRAMING];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_pulse;
      fa ##1 !fa;
   endsequence
   sequence s_rate_wr;
      cfg.wr && cfg.addr == ISO_ADDR_RATE ##1 !cfg.wr && cfg.addr == ISO_ADDR_RATE;
   endsequence
   chk_fp_drive: assert property (pins.frame_pulse_oe_n == a_q[ISO_A_FP_HIZ])
      else $error("frame pulse enable wrong");
   chk_bclk_drive: assert property (pins.bit_clock_oe_n == a_q[ISO_A_BCLK_HIZ])
      else $error("bit clock enable wrong");
   chk_embed_fp_low: assert property (a_q[ISO_A_EMBED_FRAMING] |-> !pins.frame_pulse)
      else $error("frame pulse not low in embedded mode");
   chk_pulse_one_bit: assert property (ok && r_q == 4'h1 && $rose(fa) |-> s_pulse)
      else $error("frame pulse not one bit long");
   chk_early_slot: assert property (ok && fa && !a_q[ISO_A_FP_LATE] |-> pins.serial_data_out_a)
      else $error("early pulse slot data not high");
   chk_frame_start: assert property (ok && r_q == 4'h1 && sample.valid |-> ##[1:100] fa)
      else $error("no frame after sample");
   chk_embed_start: assert property (a_q[ISO_A_EMBED_FRAMING] && qt_q == 4'hF && r_q == 4'h1
      && sample.valid |-> ##[1:100] !pins.serial_data_out_a)
      else $error("no start bit after sample");
   chk_rate_read: assert property (s_rate_wr |=> cfg_rdata == {4'h0, r_q})
      else $error("rate read back wrong");
   chk_bclk_div2: assert property (ok && r_q == 4'h2 |->
      pins.serial_bit_clock_out != $past(pins.serial_bit_clock_out))
      else $error("bit clock not half rate");
endmodule : iso_framer_chk

bind iso_framer iso_framer_chk u_chk (.mclk(mclk), .rstn(rstn), .cfg(cfg), .pins(pins),
   .cfg_rdata(cfg_rdata), .sample(sample));

// ===== bench/iso_host_rx.sv
// Host serial receiver model: records data and frame pulse once per bit
module iso_host_rx (
   input wire logic bclk, // Bit clock wire
   input wire logic data, // Serial data
   input wire logic fp // Frame pulse wire
);
   timeunit 1ns;
   timeprecision 100ps;
   logic bits[$];
   logic fps[$];
   // Data moves on the rising edge, so the falling edge sees it settled
   always @(negedge bclk) begin
      bits.push_back(data);
      fps.push_back(fp);
   end
endmodule : iso_host_rx

// ===== bench/iso_framer_bench.sv
// Testbench for the serial I/Q output framer
module iso_framer_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import iso_pkg::*;
   localparam logic [32:0] BASE = {16'hA5C3, 16'h3C5A, 1'b1};
   logic mclk, rstn, ev, gv, four_wire_cfg;
   logic [7:0] cfg_rdata;
   logic [2:0] drive_level;
   iso_cfg_t cfg;
   iso_sample_t smp;
   iso_pins_t p;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   wire bclk_w = p.bit_clock_oe_n ? 1'bz : p.serial_bit_clock_out;
   wire fp_w = p.frame_pulse_oe_n ? 1'bz : p.frame_pulse;
   iso_framer DUT (.mclk(mclk), .rstn(rstn), .cfg(cfg), .pins(p), .cfg_rdata(cfg_rdata),
      .sample(smp), .mod_reset_event(ev), .gain_variant_flag(gv), .drive_level(drive_level),
      .four_wire_cfg(four_wire_cfg));
   iso_host_rx host (.bclk(bclk_w), .data(p.serial_data_out_a), .fp(fp_w));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   task end_sim;
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         end_sim;
      end
   end
   task chk(input string nm, input logic [95:0] e, input logic [95:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task wr(input logic [5:0] ad, input logic [7:0] d);
      @(posedge mclk) #1 cfg = '{1'b1, ad, d};
      @(posedge mclk) #1 cfg.wr = 1'b0;
   endtask : wr
   task rd(input logic [5:0] ad, input logic [7:0] e);
      @(posedge mclk) #1 cfg.addr = ad;
      @(posedge mclk) #1 chk("rdata", {88'h0, e}, {88'h0, cfg_rdata});
   endtask : rd
   task pulse(input int n);
      repeat (n) begin
         @(posedge mclk) #1 ev = 1'b1;
         @(posedge mclk) #1 ev = 1'b0;
      end
   endtask : pulse
   // One frame under settings a and rate r; n bits compared from the first data bit, or from the start bit with embedded framing
   task run(input logic [7:0] a, input logic [3:0] r, input int n, input logic [95:0] e);
      int k;
      logic [95:0] got;
      wr(ISO_ADDR_CTRL_A, a);
      wr(ISO_ADDR_RATE, {4'h0, r});
      repeat (16) @(posedge mclk);
      host.bits.delete();
      host.fps.delete();
      @(posedge mclk) #1 smp.valid = 1'b1;
      @(posedge mclk) #1 smp.valid = 1'b0;
      // Long gap keeps frames inside the output period
      repeat (100 * r) @(posedge mclk);
      k = 0;
      while (k < host.bits.size() && (a[5] ? host.bits[k] !== 1'b0 : host.fps[k] === a[3])) k++;
      if (!a[5] && !a[2]) k++;
      got = '0;
      for (int j = 0; j < n; j++) got = {got[94:0], host.bits[k + j]};
      chk("frame", e, got);
   endtask : run
   task t_regs;
      rd(ISO_ADDR_CTRL_A, ISO_CTRL_A_RST);
      rd(ISO_ADDR_CTRL_B, ISO_CTRL_B_RST);
      rd(ISO_ADDR_RATE, 8'h01);
      rd(6'h20, 8'h00);
      wr(ISO_ADDR_RATE, 8'hF4);
      rd(ISO_ADDR_RATE, 8'h04);
      wr(ISO_ADDR_CTRL_B, 8'h85);
      @(posedge mclk) #1 chk("drive", 96'h85, {88'h0, four_wire_cfg, 4'h0, drive_level});
   endtask : t_regs
   task t_basic;
      run(8'h00, 4'h1, 33, BASE);
      run(8'h04, 4'h1, 33, BASE);
      run(8'h08, 4'h1, 33, BASE);
      run(8'h00, 4'h2, 33, BASE);
   endtask : t_basic
   task t_gain;
      wr(ISO_ADDR_CTRL_B, 8'h0F);
      pulse(4);
      run(8'h40, 4'h1, 65, {24'hA5C33C, 24'h3C5AF0, 8'h96, 2'h3, 6'h2B, 1'b1});
      @(posedge mclk) #1 gv = 1'b1;
      run(8'h40, 4'h1, 49, {BASE[32:1], 8'h96, 2'h0, 6'h2B, 1'b1});
      @(posedge mclk) #1 gv = 1'b0;
   endtask : t_gain
   task t_alt;
      wr(ISO_ADDR_CTRL_B, 8'h07);
      pulse(1);
      // Odd attenuation and even strength, so the forced marker bits show
      smp.atten = 8'h97;
      run(8'hC0, 4'h1, 41, {BASE[32:1], 8'h96, 1'b1});
      smp.signal_strength_field = 6'h2A;
      run(8'hC0, 4'h1, 41, {BASE[32:1], 2'h1, 6'h2B, 1'b1});
   endtask : t_alt
   task t_embed;
      run(8'h20, 4'h1, 50, {1'b0, 8'hA5, 2'b10, 8'hC3, 2'b10, 8'h3C, 2'b10, 8'h5A, 1'b1, 10'h3FF});
   endtask : t_embed
   initial begin
      cfg = '0;
      smp = '{1'b0, 24'hA5C33C, 24'h3C5AF0, 8'h96, 6'h2B};
      ev = 1'b0;
      gv = 1'b0;
      rstn = 1'b0;
      repeat (16) @(posedge mclk);
      #1 rstn = 1'b1;
      t_regs;
      t_basic;
      t_gain;
      t_alt;
      t_embed;
      end_sim;
   end
endmodule : iso_framer_bench
